// ### rtl/vsad_pkg.sv
package vsad_pkg;
	// Clock and timing
	localparam int unsigned CLK_NS = 10;
	localparam int unsigned GLITCH_NS = 100;
	localparam int unsigned GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned GREEN_RUN = 64;
	// Sizes
	localparam int NCH = 2;
	localparam int NMON = 6;
	localparam int CW = 24;
	localparam int MW = 16;
	localparam int HW = 4;
	localparam int RW = 7;
	localparam int AW = 12;
	localparam logic [HW-1:0] HOLD_LD = HW'(GLITCH_CYC - 1);
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_ACT = 8'h01;
	localparam logic [7:0] IDX_POL = 8'h02;
	localparam logic [7:0] IDX_GSL = 8'h04;
	localparam logic [7:0] IDX_CFG = 8'h05;
	localparam logic [7:0] IDX_STRB = 8'h06;
	localparam logic [7:0] IDX_PWR = 8'h07;
	// Reset values
	localparam logic [7:0] GSL_RST = 8'h16;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] STRB_RST = 8'h01;
	localparam logic [7:0] PWR_RST = 8'h00;
	// Field positions
	localparam int CFG_CH = 0;
	localparam int CFG_SRC = 3;
	localparam int STRB_W = 0;
	localparam int STRB_VPOL = 6;
	localparam int STRB_HPOL = 7;
	localparam int PWR_BIT = 0;
	localparam int MON_VS = 2;
	localparam int MON_GS = 4;
	localparam logic [1:0] SRC_SEP = 2'h0;
	localparam logic [1:0] SRC_CHS = 2'h1;
	localparam logic [1:0] SRC_GRN = 2'h2;

	typedef struct packed {
		logic [NCH-1:0] hs;
		logic [NCH-1:0] vs;
		logic [NCH-1:0] gs;
		logic [NCH-1:0] tlv;
	} vsad_pins_t;

	typedef struct packed {
		vsad_pins_t s1;
		vsad_pins_t s2;
		logic odc1;
		logic odc2;
		logic odcp;
		logic [NCH-1:0] hsf;
		logic [NCH-1:0][HW-1:0] hold;
		logic [NMON-1:0] prv;
		logic [NMON-1:0][2:0] ecnt;
		logic [NMON-1:0] act;
		logic [NMON-1:0][CW-1:0] hic;
		logic [NMON-1:0] pol;
		logic [CW-1:0] win;
		logic [NCH-1:0][MW-1:0] gper;
		logic [NCH-1:0][MW-1:0] ghi;
		logic [NCH-1:0][MW-1:0] lper;
		logic [NCH-1:0][MW-1:0] lhi;
		logic [NCH-1:0][RW-1:0] run;
		logic [NCH-1:0] gok;
		logic [NCH-1:0] tprv;
		logic [NCH-1:0] tseen;
		logic tact;
		logic [MW-1:0] cw;
		logic cactp;
		logic cseen;
		logic cpres;
		logic lpend;
		logic [2:0] lcnt;
		logic lstr;
		logic fstr;
		logic [7:0] gsl;
		logic [7:0] cfg;
		logic [7:0] strb;
		logic [7:0] pwr;
		logic [31:0] rdata;
		logic rdy;
		logic err;
	} vsad_st_t;

	// Polarity starts active-high so the idle-low line sync gives no false strobe edge after reset
	localparam vsad_st_t ST_RST = '{gsl: GSL_RST, cfg: CFG_RST, strb: STRB_RST, pwr: PWR_RST, pol: '1, default: '0};
endpackage

// ### rtl/vsad_sync_detect.sv
// Contract
// [RULE1] Ignore line sync transitions within 100ns
// [RULE2] Firmware: line slicer code 001b or 110b
// [RULE3] Firmware: green slicer control defaults to 0x16
// [RULE4] Monitor six sync inputs, report activity, polarity
// [RULE5] Firmware checks patterns in fixed priority order
// [RULE6] Firmware maps activity patterns to sync source
// [RULE7] Firmware selects composite source, confirms present bit
// [RULE8] Firmware keeps green sync low pass enabled
// [RULE9] Green activity needs 64 matching consecutive pulses
// [RULE10] Firmware prefers line and frame activity
// [RULE11] Green activity valid only without line activity
// [RULE12] Trilevel detect needs no 64 pulse run
// [RULE13] Firmware qualifies trilevel with line and green
// [RULE14] Firmware polls trilevel bit several times
// [RULE15] Composite present on long pulse, composite source
// [RULE16] Raw sync outputs copy inputs, no resync
// [RULE17] Line and frame strobes on data clock
// [RULE18] Raw outputs keep running in power-down
// [RULE19] Detectors and status keep running in standby
// [RULE20] Status registers read-only, reads show live state
// [RULE21] Detector inputs synchronised before use
//
// Chosen here: the APB interface to the registers.
module vsad_sync_detect
	import vsad_pkg::*;
#(
	parameter int unsigned ACT_WINDOW = 2_000_000,
	parameter int unsigned ACT_EDGES = 4,
	parameter int unsigned GREEN_TOL = 2,
	parameter int unsigned COMP_MIN_W = 1500
)(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Sync pins
	input wire vsad_pins_t sync_pins,
	input wire logic output_data_clock,
	// Sync outputs
	output logic hsync_out,
	output logic vsync_out,
	output logic line_start_strobe,
	output logic frame_sync_strobe,
	// Analog front end controls
	output logic [7:0] green_slicer_ctrl,
	output logic [7:0] input_cfg,
	output logic power_down
);
	localparam logic [CW-1:0] WIN_LD = CW'(ACT_WINDOW - 1);
	localparam logic [CW-1:0] HALF_WIN = CW'(ACT_WINDOW / 2);
	localparam logic [2:0] EDGE_MIN = 3'(ACT_EDGES);
	localparam logic [MW-1:0] TOL = MW'(GREEN_TOL);
	localparam logic [MW-1:0] COMP_W = MW'(COMP_MIN_W);
	localparam logic [RW-1:0] RUN_MAX = RW'(GREEN_RUN);

	vsad_st_t q;
	vsad_st_t d;
	logic ch;
	logic [1:0] src;
	logic pdn;
	logic [NMON-1:0] mon;
	logic wend;
	logic tick;
	logic csig;
	logic cact;
	logic hit;
	logic mapped;
	logic [7:0] idx;
	logic [7:0] stat;
	logic [7:0] rd;

	function automatic logic near(input logic [MW-1:0] a, input logic [MW-1:0] b);
		logic [MW-1:0] diff;
		diff = (a > b) ? a - b : b - a;
		return diff <= TOL;
	endfunction

	function automatic logic [7:0] ridx(input logic [AW-1:0] a);
		return a[9:2];
	endfunction

	function automatic logic aok(input logic [AW-1:0] a);
		return (a[1:0] == 2'h0) && (a[AW-1:10] == 2'h0);
	endfunction

	assign ch = q.cfg[CFG_CH];
	assign src = q.cfg[CFG_SRC +: 2];
	assign pdn = q.pwr[PWR_BIT];

	// Raw copies stay combinational so mode detection sees true edges, even when powered down
	assign hsync_out = (src == SRC_GRN) ? sync_pins.gs[ch] : sync_pins.hs[ch]; // [RULE16] [RULE18]
	assign vsync_out = sync_pins.vs[ch]; // [RULE16] [RULE18]

	assign prdata = q.rdata;
	assign pready = q.rdy;
	assign pslverr = q.err;
	assign line_start_strobe = q.lstr;
	assign frame_sync_strobe = q.fstr;
	assign green_slicer_ctrl = q.gsl;
	assign input_cfg = q.cfg;
	assign power_down = q.pwr[PWR_BIT];

	always_comb
	begin
		d = q;
		// Two flops on every pin before any detector reads it
		d.s1 = sync_pins; // [RULE21]
		d.s2 = q.s1; // [RULE21]
		d.odc1 = output_data_clock;
		d.odc2 = q.odc1;
		d.odcp = q.odc2;
		tick = q.odc2 & ~q.odcp;
		wend = (q.win == '0);

		// Line sync glitch filter
		for (int c = 0; c < NCH; c++)
		begin
			if (q.hold[c] != '0)
				d.hold[c] = q.hold[c] - 1'b1; // [RULE1]
			else if (q.s2.hs[c] != q.hsf[c])
			begin
				d.hsf[c] = q.s2.hs[c]; // [RULE1]
				d.hold[c] = HOLD_LD; // [RULE1]
			end
		end

		// Activity and polarity over a free-running window; power state never stops it
		mon = {q.s2.gs, q.s2.vs, q.hsf};
		d.prv = mon;
		d.win = wend ? WIN_LD : q.win - 1'b1; // [RULE19]
		for (int m = 0; m < NMON; m++)
		begin
			if (wend)
			begin
				d.act[m] = q.ecnt[m] >= EDGE_MIN; // [RULE4]
				d.pol[m] = q.hic[m] < HALF_WIN; // [RULE4]
				d.ecnt[m] = '0;
				d.hic[m] = '0;
			end
			else
			begin
				if (mon[m] != q.prv[m] && q.ecnt[m] != '1)
					d.ecnt[m] = q.ecnt[m] + 1'b1;
				if (mon[m])
					d.hic[m] = q.hic[m] + 1'b1;
			end
		end

		// Green sync: run of pulses with matching period and duty cycle
		for (int c = 0; c < NCH; c++)
		begin
			if (q.gper[c] != '1)
				d.gper[c] = q.gper[c] + 1'b1;
			if (q.s2.gs[c] && q.ghi[c] != '1)
				d.ghi[c] = q.ghi[c] + 1'b1;
			if (q.s2.gs[c] && !q.prv[MON_GS + c])
			begin
				d.lper[c] = q.gper[c];
				d.lhi[c] = q.ghi[c];
				d.gper[c] = MW'(1);
				d.ghi[c] = MW'(1);
				if (near(q.gper[c], q.lper[c]) && near(q.ghi[c], q.lhi[c]))
				begin
					if (q.run[c] != RUN_MAX)
						d.run[c] = q.run[c] + 1'b1; // [RULE9]
					if (q.run[c] == RUN_MAX - 1'b1)
						d.gok[c] = 1'b1; // [RULE9]
				end
				else
				begin
					d.run[c] = RW'(1); // [RULE9]
					d.gok[c] = 1'b0; // [RULE9]
				end
			end
			if (wend && q.ecnt[MON_GS + c] == '0)
			begin
				d.run[c] = '0;
				d.gok[c] = 1'b0;
			end
		end

		// Trilevel: any pulse in the window is enough, so it is the weaker indicator
		d.tprv = q.s2.tlv;
		if (wend)
		begin
			d.tact = q.tseen[ch]; // [RULE12]
			d.tseen = '0;
		end
		for (int c = 0; c < NCH; c++)
		begin
			if (q.s2.tlv[c] && !q.tprv[c])
				d.tseen[c] = 1'b1; // [RULE12]
		end

		// Composite presence: an overlong active pulse means a frame interval is embedded
		csig = (src == SRC_GRN) ? q.s2.gs[ch] : q.hsf[ch];
		cact = ~(csig ^ ((src == SRC_GRN) ? q.pol[MON_GS + ch] : q.pol[ch]));
		d.cactp = cact;
		if (wend)
		begin
			d.cpres = q.cseen; // [RULE15]
			d.cseen = 1'b0;
		end
		if (cact)
		begin
			if (q.cw != '1)
				d.cw = q.cw + 1'b1;
			if (q.cw >= COMP_W)
				d.cseen = 1'b1; // [RULE15]
		end
		else
			d.cw = '0;
		if (src == SRC_SEP)
			d.cpres = 1'b0; // [RULE15]

		// Strobes move only on data clock ticks, so they stay aligned with pixel data
		if (tick)
		begin
			if (q.lpend && !pdn)
				d.lcnt = q.strb[STRB_W +: 3]; // [RULE17]
			else if (pdn)
				d.lcnt = '0;
			else if (q.lcnt != '0)
				d.lcnt = q.lcnt - 1'b1; // [RULE17]
			d.lpend = 1'b0;
			d.lstr = (d.lcnt != '0) ^ q.strb[STRB_HPOL]; // [RULE17]
			d.fstr = (~(q.s2.vs[ch] ^ q.pol[MON_VS + ch]) & ~pdn) ^ q.strb[STRB_VPOL]; // [RULE17]
		end
		if (cact && !q.cactp)
			d.lpend = 1'b1; // [RULE17]

		// APB: one wait state, data and error registered with pready
		idx = ridx(paddr);
		mapped = aok(paddr);
		stat = {q.cpres, q.tact, q.gok, q.act[MON_GS-1:0]};
		rd = '0;
		hit = 1'b1;
		if (!mapped)
			hit = 1'b0;
		else if (idx == IDX_ACT)
			rd = stat; // [RULE4] [RULE20]
		else if (idx == IDX_POL)
			rd = 8'(q.pol); // [RULE4] [RULE20]
		else if (idx == IDX_GSL)
			rd = q.gsl;
		else if (idx == IDX_CFG)
			rd = q.cfg;
		else if (idx == IDX_STRB)
			rd = q.strb;
		else if (idx == IDX_PWR)
			rd = q.pwr;
		else
			hit = 1'b0;
		d.rdy = 1'b0;
		d.err = 1'b0;
		if (psel && penable && !q.rdy)
		begin
			d.rdy = 1'b1;
			d.err = ~hit;
			d.rdata = pwrite ? '0 : 32'(rd);
		end
		// Status indices fall through: writes there are dropped without error
		if (psel && penable && q.rdy && pwrite && hit)
		begin
			if (idx == IDX_GSL)
				d.gsl = pwdata[7:0];
			else if (idx == IDX_CFG)
			begin
				d.cfg = pwdata[7:0];
				if (pwdata[CFG_SRC +: 2] == SRC_SEP)
					d.cpres = 1'b0; // [RULE15]
			end
			else if (idx == IDX_STRB)
				d.strb = pwdata[7:0];
			else if (idx == IDX_PWR)
				d.pwr = pwdata[7:0]; // [RULE20]
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= ST_RST;
		else
			q <= d;
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_act_read;
		psel && penable && !q.rdy && !pwrite && aok(paddr) && ridx(paddr) == IDX_ACT;
	endsequence

	sequence s_bad_addr;
		psel && penable && !q.rdy && !aok(paddr);
	endsequence

	a_hs_hold_load: assert property ($changed(q.hsf[0]) |-> q.hold[0] == HOLD_LD) // [RULE1]
		else $error("line sync filter did not start its hold time");
	a_hs_glitch_hold: assert property (q.hold[0] != '0 |=> $stable(q.hsf[0])) // [RULE1]
		else $error("line sync filter accepted a transition inside the hold time");
	a_hs_from_sync: assert property ($changed(q.hsf[0]) |-> q.hsf[0] == $past(q.s2.hs[0])) // [RULE21]
		else $error("line sync filter took a value other than the synchronised pin");
	a_green_run_64: assert property ($rose(q.gok[0]) |-> $past(q.run[0]) == 63) // [RULE9]
		else $error("green activity set before 64 matching pulses");
	a_act_read_live: assert property (s_act_read |=> pready && !pslverr && prdata[7:0] == $past(stat)) // [RULE4]
		else $error("status read did not return detector state");
	a_status_ro_write: assert property (psel && penable && q.rdy && pwrite && ridx(paddr) == IDX_ACT |=> $stable(q.cfg) && $stable(q.gsl)) // [RULE20]
		else $error("write to status index changed a register");
	a_unmapped_err: assert property (s_bad_addr |=> pready && pslverr ##1 !pready) // [RULE20]
		else $error("unmapped access not answered with error");
	a_tri_window: assert property ($changed(q.tact) |-> $past(wend)) // [RULE12]
		else $error("trilevel status changed outside window end");
	a_comp_source: assert property (q.cpres |-> src != SRC_SEP) // [RULE15]
		else $error("composite present set with separate syncs selected");
	a_window_runs: assert property (pdn && q.win != '0 |=> q.win == $past(q.win) - 1'b1) // [RULE19]
		else $error("activity window stalled in standby");
	a_line_on_tick: assert property ($changed(q.lstr) || $changed(q.fstr) |-> $past(tick)) // [RULE17]
		else $error("strobe changed off the data clock");
endmodule

// ### verif/test_video_sync_activity_detect.sv
module test_video_sync_activity_detect
	import vsad_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [AW-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic odc = 0;
	logic [4:0] en = '0;
	vsad_pins_t pins;
	logic hsync_out, vsync_out, line_start_strobe, frame_sync_strobe, power_down;
	logic [7:0] gsl, cfg;
	logic [31:0] r;
	logic e;
	int miscompares = 0;
	int checked = 0;

	always #5 pclk = ~pclk;
	always @(posedge pclk) odc <= ~odc;

	vsad_src_model src (.clk(pclk), .en(en), .pins(pins));

	vsad_sync_detect #(.ACT_WINDOW(200), .COMP_MIN_W(20)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sync_pins(pins), .output_data_clock(odc), .hsync_out(hsync_out), .vsync_out(vsync_out),
		.line_start_strobe(line_start_strobe), .frame_sync_strobe(frame_sync_strobe),
		.green_slicer_ctrl(gsl), .input_cfg(cfg), .power_down(power_down));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Firmware view of channel 0: first matching pattern wins
	function automatic int classify(input logic [7:0] s);
		if (s[0] && s[2])
			return 1;
		else if (s[0])
			return 2;
		else if (!s[2] && s[4] && s[6])
			return 4;
		else if (!s[2] && s[4])
			return 3;
		else
			return 0;
	endfunction

	task automatic wait_high(input logic frame);
		int n;
		n = 0;
		while ((frame ? frame_sync_strobe : line_start_strobe) !== 1'b1 && n < 200)
		begin
			@(posedge pclk);
			n++;
		end
		chk(frame ? frame_sync_strobe : line_start_strobe, 1'b1);
		if (n >= 200)
			summarize();
	endtask

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		if (n >= 20)
		begin
			miscompares++;
			summarize();
		end
	endtask

	task automatic rd(input logic [AW-1:0] a, input logic [31:0] exp, input logic [31:0] m);
		apb(0, a, '0);
		chk(r & m, exp);
	endtask

	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1;
		// Reset values, default green slicer setting left as is
		rd(12'h010, 32'h0000_0016, 32'hFFFF_FFFF);
		chk(gsl, 8'h16);
		rd(12'h014, 32'h0000_0000, 32'hFFFF_FFFF);
		rd(12'h018, 32'h0000_0001, 32'hFFFF_FFFF);
		rd(12'h01C, 32'h0000_0000, 32'hFFFF_FFFF);
		apb(0, 12'h020, '0);
		chk(e, 1'b1);
		// Out-of-range address aliasing the green slicer index must not write it
		apb(1, 12'h410, 32'h0000_00AA);
		chk(e, 1'b1);
		rd(12'h010, 32'h0000_0016, 32'hFFFF_FFFF);
		$display("test registers done");
		// Separate line and frame sync, writes to status ignored
		en <= 5'h03;
		apb(1, 12'h004, 32'h0000_00FF);
		chk(e, 1'b0);
		apb(1, 12'h008, 32'h0000_0000);
		repeat (600) @(posedge pclk);
		rd(12'h004, 32'h0000_0005, 32'hFFFF_FFFF);
		chk(classify(r[7:0]), 32'd1);
		// Idle inputs are never high for half a window, so they read as active-high
		rd(12'h008, 32'h0000_003F, 32'hFFFF_FFFF);
		repeat (100) @(posedge pclk);
		wait_high(1'b0);
		wait_high(1'b1);
		$display("test separate sync done");
		// Power-down: raw outputs and detectors keep running, strobes idle
		apb(1, 12'h01C, 32'h0000_0001);
		// Strobes go idle only at the next data clock tick
		repeat (4) @(negedge pclk);
		chk(power_down, 1'b1);
		repeat (400)
		begin
			@(negedge pclk);
			chk({hsync_out, vsync_out, line_start_strobe, frame_sync_strobe}, {pins.hs[0], pins.vs[0], 2'b00});
		end
		rd(12'h004, 32'h0000_0005, 32'hFFFF_FFFF);
		apb(1, 12'h01C, 32'h0000_0000);
		$display("test power-down done");
		// Green sync with trilevel: trilevel early, green only after the run
		en <= 5'h0C;
		repeat (1600) @(posedge pclk);
		rd(12'h004, 32'h0000_0040, 32'h0000_0070);
		repeat (1600) @(posedge pclk);
		rd(12'h004, 32'h0000_0050, 32'h0000_007F);
		begin : poll_tri
			logic [7:0] seen;
			seen = '0;
			repeat (3)
			begin
				apb(0, 12'h004, '0);
				seen = r[7:0] | (seen & 8'h40);
			end
			chk(classify(seen), 32'd4);
		end
		apb(1, 12'h014, 32'h0000_0010);
		repeat (4) @(negedge pclk);
		chk(cfg, 8'h10);
		chk(hsync_out, pins.gs[0]);
		$display("test green sync done");
		// Composite on line sync with a long embedded pulse
		apb(1, 12'h014, 32'h0000_0008);
		// Green keeps running, so line sync must still win the classification
		en <= 5'h15;
		repeat (600) @(posedge pclk);
		rd(12'h004, 32'h0000_0091, 32'h0000_00FF);
		chk(classify(r[7:0]), 32'd2);
		$display("test composite done");
		summarize();
	end
endmodule

// ### verif/vsad_src_model.sv
module vsad_src_model
	import vsad_pkg::*;
(
	// Clock
	input wire logic clk,
	// Enables: line, frame, green, trilevel, long pulse
	input wire logic [4:0] en,
	// Sync pins
	output vsad_pins_t pins
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	always @(posedge clk)
	begin
		cnt <= (cnt == 79) ? 0 : cnt + 1;
	end
	// Channel 1 stays idle so cross-channel leakage shows up
	always_comb
	begin
		pins = '0;
		// Clean rail-to-rail edges, so either recommended line slicer code locks alike
		pins.hs[0] = en[0] && ((cnt % 40) < 4 || (en[4] && cnt < 30));
		pins.vs[0] = en[1] && cnt < 8;
		pins.gs[0] = en[2] && (cnt % 40) < 4;
		pins.tlv[0] = en[3] && (cnt % 40) == 20;
	end
endmodule
